/* rtl/pafn_pkg.sv */
// Purpose: constants for the port A pin function block
// Assumes: APB with 32-bit data, one aligned word per register
// Notes: register byte address is four times the register index
//
// How it works
// R01: pin four only pulls low or floats; it never drives high.
// R02: in clock-out oscillator modes pin six carries a quarter-rate clock.
// R03: with master clear selected, a low pin five holds the device in reset.
// R04: a config bit makes pin five input-only or the master clear input.
// R05: power-on clears latch bits 3:0; other resets keep bits 7:4.
// R06: unimplemented bits read zero and ignore writes.
// R07: pin four feeds the timer zero clock and the second comparator output.
// R08: direction bit one floats the pin, zero drives it from the latch.
// R09: port read gives pin levels; writes merge into latch from the pins.
// R10: pins used as comparator inputs read zero through the port register.
// R11: oscillator-owned pins 7:6 read zero and ignore their direction bits.
// R12: an enabled comparator, reference or oscillator function overrides latch and direction of its pin; the timer clock does not.
package pafn_pkg;

	////////////////////////////////////////////////////////////////////////
	// register map
	localparam int PAFN_ADDR_WIDTH = 12;
	localparam logic [9:0] IDX_PORT_A_LATCH = 10'h005;
	localparam logic [9:0] IDX_COMPARATOR_CONTROL = 10'h01F;
	localparam logic [9:0] IDX_PORT_A_DIRECTION = 10'h085;
	localparam logic [9:0] IDX_VOLTAGE_REF_CONTROL = 10'h09F;
	localparam logic [9:0] IDX_DEVICE_CONFIG = 10'h0A0;
	localparam logic [11:0] ADDR_PORT_A_LATCH = {IDX_PORT_A_LATCH, 2'h0};
	localparam logic [11:0] ADDR_COMPARATOR_CONTROL =
		{IDX_COMPARATOR_CONTROL, 2'h0};
	localparam logic [11:0] ADDR_PORT_A_DIRECTION = {IDX_PORT_A_DIRECTION, 2'h0};
	localparam logic [11:0] ADDR_VOLTAGE_REF_CONTROL =
		{IDX_VOLTAGE_REF_CONTROL, 2'h0};
	localparam logic [11:0] ADDR_DEVICE_CONFIG = {IDX_DEVICE_CONFIG, 2'h0};

	////////////////////////////////////////////////////////////////////////
	// reset values and masks
	localparam logic [7:0] RST_PORT_A_LATCH = 8'h00;
	localparam logic [7:0] LATCH_KEEP_MASK = 8'hF0;
	localparam logic [7:0] RST_PORT_A_DIRECTION = 8'hFF;
	localparam logic [7:0] RST_COMPARATOR_CONTROL = 8'h00;
	localparam logic [7:0] COMPARATOR_WRITE_MASK = 8'h3F;
	localparam logic [7:0] RST_VOLTAGE_REF_CONTROL = 8'h00;
	localparam logic [7:0] VREF_IMPL_MASK = 8'hEF;
	localparam logic [7:0] RST_DEVICE_CONFIG = 8'h01;
	localparam logic [7:0] CONFIG_IMPL_MASK = 8'h0F;

	////////////////////////////////////////////////////////////////////////
	// comparator control fields
	localparam int CMP_C2OUT = 7;
	localparam int CMP_C1OUT = 6;
	localparam int CMP_C2INV = 5;
	localparam int CMP_C1INV = 4;
	localparam int CMP_CIS = 3;
	localparam int CMP_MODE_LSB = 0;
	localparam logic [2:0] CMP_MODE_OFF = 3'h7;
	localparam logic [2:0] CMP_MODE_OUTPUTS = 3'h6;
	localparam logic [7:0] ANALOG_MASK_ALL = 8'h0F;
	localparam logic [7:0] ANALOG_MASK_OUTPUTS = 8'h07;

	////////////////////////////////////////////////////////////////////////
	// voltage reference fields
	localparam int VREF_EN = 7;
	localparam int VREF_OE = 6;
	localparam int VREF_RANGE = 5;
	localparam int VREF_LEVEL_LSB = 0;

	////////////////////////////////////////////////////////////////////////
	// device configuration fields and oscillator modes
	localparam int CFG_MASTER_CLEAR_RESET_SEL = 0;
	localparam int CFG_OSC_LSB = 1;
	localparam int CFG_T0_SEL = 3;
	localparam logic [1:0] OSC_INTERNAL_IO = 2'h0;
	localparam logic [1:0] OSC_INTERNAL_QUARTER_CLOCK_OUTPUT = 2'h1;
	localparam logic [1:0] OSC_RC_QUARTER_CLOCK_OUTPUT = 2'h2;
	localparam logic [1:0] OSC_CRYSTAL = 2'h3;
	localparam logic [7:0] OSC_MASK_NONE = 8'h00;
	localparam logic [7:0] OSC_MASK_QUARTER_CLOCK_OUTPUT = 8'h40;
	localparam logic [7:0] OSC_MASK_BOTH = 8'hC0;

	////////////////////////////////////////////////////////////////////////
	// pin positions and divider count
	localparam int PIN_VREF = 2;
	localparam int PIN_CMP1 = 3;
	localparam int PIN_FOUR = 4;
	localparam int PIN_FIVE = 5;
	localparam int PIN_QUARTER_CLOCK_OUTPUT = 6;
	localparam int PIN_OSC_IN = 7;
	localparam logic QUARTER_HALF_EDGES_M1 = 1'h1;

endpackage

/* rtl/pafn_quarter_div.sv */
// Purpose: quarter-rate clock from the primary oscillator level
// Assumes: oscillator level is synchronous and below half the core clock
// Notes: output toggles every second rising edge of the input
`timescale 1ns/1ps
module pafn_quarter_div
	import pafn_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// oscillator level in, divided clock out
	input wire logic osc_level,
	output logic quarter
);

	logic prev;
	logic edge_count;
	logic next_prev;
	logic next_edge_count;
	logic next_quarter;

	////////////////////////////////////////////////////////////////////////
	// count rising edges, toggle after every second one
	always_comb
	begin
		next_prev = osc_level;
		next_edge_count = edge_count;
		next_quarter = quarter;
		if (osc_level && !prev)
		begin
			if (edge_count == QUARTER_HALF_EDGES_M1)
			begin
				next_edge_count = 1'h0;
				next_quarter = !quarter; // R02
			end
			else
			begin
				next_edge_count = edge_count + 1'h1;
			end
		end
	end

	// register divider state
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			prev <= 1'h0;
			edge_count <= 1'h0;
			quarter <= 1'h0;
		end
		else
		begin
			prev <= next_prev;
			edge_count <= next_edge_count;
			quarter <= next_quarter;
		end
	end

endmodule

/* rtl/pafn_top.sv */
// Purpose: port A pins with comparator, reference, timer and clock functions
// Assumes: pins sampled synchronously; APB slave with zero wait states
// Notes: all outputs registered; pin five has no output driver
//
// The APB register port was left to the implementer.
`timescale 1ns/1ps
module pafn_top
	import pafn_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [PAFN_ADDR_WIDTH-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// port pins
	input wire logic [7:0] pin_in,
	output logic [7:0] pin_out,
	output logic [7:0] pin_oe,
	// analog and clock sources
	input wire logic internal_oscillator,
	input wire logic cmp1_result,
	input wire logic second_comparator_output_result,
	// controls to analog blocks and timer
	output logic [2:0] comparator_mode,
	output logic comparator_input_switch,
	output logic vref_enable,
	output logic vref_pin_enable,
	output logic vref_range,
	output logic [3:0] vref_level,
	output logic timer_zero_ext_clock,
	output logic master_clear_reset
);

	logic [7:0] port_a_latch;
	logic [7:0] port_a_direction;
	logic [7:0] comparator_control;
	logic [7:0] voltage_ref_control;
	logic [7:0] device_config;
	logic [7:0] next_port_a_latch;
	logic [7:0] next_port_a_direction;
	logic [7:0] next_comparator_control;
	logic [7:0] next_voltage_ref_control;
	logic [7:0] next_device_config;
	logic [31:0] next_prdata;
	logic next_pready;
	logic next_pslverr;
	logic [7:0] next_pin_out;
	logic [7:0] next_pin_oe;
	logic next_timer_zero_ext_clock;
	logic next_master_clear_reset;
	logic [7:0] analog_mask;
	logic [7:0] osc_mask;
	logic [7:0] port_read;
	logic c1out;
	logic c2out;
	logic [1:0] osc_mode;
	logic cmp_outputs_on;
	logic primary_oscillator_input;
	logic quarter_clock_output;
	logic setup;
	logic write_now;

	////////////////////////////////////////////////////////////////////////
	// decoded configuration and pin ownership
	always_comb
	begin
		osc_mode = device_config[CFG_OSC_LSB +: 2];
		cmp_outputs_on = (comparator_mode == CMP_MODE_OUTPUTS);
		c1out = cmp1_result ^ comparator_control[CMP_C1INV];
		c2out = second_comparator_output_result ^ comparator_control[CMP_C2INV];
		case (comparator_mode)
			CMP_MODE_OFF: analog_mask = 8'h00;
			CMP_MODE_OUTPUTS: analog_mask = ANALOG_MASK_OUTPUTS;
			default: analog_mask = ANALOG_MASK_ALL;
		endcase
		if (vref_enable && vref_pin_enable)
		begin
			analog_mask[PIN_VREF] = 1'h1;
		end
		case (osc_mode)
			OSC_INTERNAL_IO: osc_mask = OSC_MASK_NONE;
			OSC_INTERNAL_QUARTER_CLOCK_OUTPUT: osc_mask = OSC_MASK_QUARTER_CLOCK_OUTPUT;
			default: osc_mask = OSC_MASK_BOTH;
		endcase
		port_read = pin_in & ~analog_mask & ~osc_mask; // R10 R11
		if (osc_mode == OSC_RC_QUARTER_CLOCK_OUTPUT || osc_mode == OSC_CRYSTAL)
		begin
			primary_oscillator_input = pin_in[PIN_OSC_IN];
		end
		else
		begin
			primary_oscillator_input = internal_oscillator;
		end
	end

	// quarter-rate clock for the clock-out pin
	pafn_quarter_div u_quarter_div (
		.clock(clock),
		.sys_rst(sys_rst),
		.osc_level(primary_oscillator_input),
		.quarter(quarter_clock_output)
	);

	////////////////////////////////////////////////////////////////////////
	// apb decode, register writes and device reset effects
	always_comb
	begin
		setup = psel && !penable;
		write_now = psel && penable && pready && pwrite;
		next_port_a_latch = port_a_latch;
		next_port_a_direction = port_a_direction;
		next_comparator_control = comparator_control;
		next_voltage_ref_control = voltage_ref_control;
		next_device_config = device_config;
		next_pready = setup;
		next_pslverr = 1'h0;
		next_prdata = prdata;
		if (setup)
		begin
			next_prdata = 32'h0000_0000;
			case (paddr)
				ADDR_PORT_A_LATCH: next_prdata[7:0] = port_read; // R09
				ADDR_PORT_A_DIRECTION: next_prdata[7:0] = port_a_direction;
				ADDR_COMPARATOR_CONTROL:
				begin
					next_prdata[7:0] = comparator_control;
					next_prdata[CMP_C2OUT] = c2out;
					next_prdata[CMP_C1OUT] = c1out;
				end
				ADDR_VOLTAGE_REF_CONTROL:
					next_prdata[7:0] = voltage_ref_control; // R06
				ADDR_DEVICE_CONFIG: next_prdata[7:0] = device_config;
				default: next_pslverr = 1'h1;
			endcase
		end
		if (write_now && !master_clear_reset)
		begin
			case (paddr)
				ADDR_PORT_A_LATCH:
				begin
					// unstrobed write stores the pin levels back
					next_port_a_latch = pstrb[0] ? pwdata[7:0] : port_read; // R09
				end
				ADDR_PORT_A_DIRECTION:
				begin
					if (pstrb[0])
					begin
						next_port_a_direction = pwdata[7:0];
					end
				end
				ADDR_COMPARATOR_CONTROL:
				begin
					if (pstrb[0])
					begin
						next_comparator_control = pwdata[7:0] &
							COMPARATOR_WRITE_MASK;
					end
				end
				ADDR_VOLTAGE_REF_CONTROL:
				begin
					if (pstrb[0])
					begin
						next_voltage_ref_control = pwdata[7:0] &
							VREF_IMPL_MASK; // R06
					end
				end
				ADDR_DEVICE_CONFIG:
				begin
					if (pstrb[0])
					begin
						next_device_config = pwdata[7:0] & CONFIG_IMPL_MASK;
					end
				end
				default: next_pslverr = 1'h0;
			endcase
		end
		// master clear: low nibble cleared, upper latch bits kept
		if (master_clear_reset)
		begin
			next_port_a_latch = port_a_latch & LATCH_KEEP_MASK; // R05
			next_port_a_direction = RST_PORT_A_DIRECTION;
			next_comparator_control = RST_COMPARATOR_CONTROL;
			next_voltage_ref_control = RST_VOLTAGE_REF_CONTROL;
		end
	end

	// register file and bus answer
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			port_a_latch <= RST_PORT_A_LATCH; // R05
			port_a_direction <= RST_PORT_A_DIRECTION;
			comparator_control <= RST_COMPARATOR_CONTROL;
			voltage_ref_control <= RST_VOLTAGE_REF_CONTROL;
			device_config <= RST_DEVICE_CONFIG;
			prdata <= 32'h0000_0000;
			pready <= 1'h0;
			pslverr <= 1'h0;
		end
		else
		begin
			port_a_latch <= next_port_a_latch;
			port_a_direction <= next_port_a_direction;
			comparator_control <= next_comparator_control;
			voltage_ref_control <= next_voltage_ref_control;
			device_config <= next_device_config;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	// control fields straight from their register bits
	assign comparator_mode = comparator_control[CMP_MODE_LSB +: 3];
	assign comparator_input_switch = comparator_control[CMP_CIS];
	assign vref_enable = voltage_ref_control[VREF_EN];
	assign vref_pin_enable = voltage_ref_control[VREF_OE];
	assign vref_range = voltage_ref_control[VREF_RANGE];
	assign vref_level = voltage_ref_control[VREF_LEVEL_LSB +: 4];

	////////////////////////////////////////////////////////////////////////
	// pin drivers, timer clock and master clear
	always_comb
	begin
		next_pin_out = port_a_latch; // R08
		next_pin_oe = ~port_a_direction & ~analog_mask; // R08 R12
		if (cmp_outputs_on)
		begin
			next_pin_out[PIN_CMP1] = c1out; // R12
			next_pin_oe[PIN_CMP1] = 1'h1;
		end
		// pin four: pull low or release only
		next_pin_out[PIN_FOUR] = 1'h0; // R01
		if (cmp_outputs_on)
		begin
			next_pin_oe[PIN_FOUR] = !c2out; // R07 R12
		end
		else
		begin
			next_pin_oe[PIN_FOUR] = !port_a_direction[PIN_FOUR] &&
				!port_a_latch[PIN_FOUR]; // R01
		end
		next_pin_out[PIN_FIVE] = 1'h0;
		next_pin_oe[PIN_FIVE] = 1'h0; // R04
		if (osc_mask[PIN_QUARTER_CLOCK_OUTPUT])
		begin
			next_pin_out[PIN_QUARTER_CLOCK_OUTPUT] = quarter_clock_output; // R02
			next_pin_oe[PIN_QUARTER_CLOCK_OUTPUT] = (osc_mode != OSC_CRYSTAL); // R11
		end
		if (osc_mask[PIN_OSC_IN])
		begin
			next_pin_out[PIN_OSC_IN] = 1'h0;
			next_pin_oe[PIN_OSC_IN] = 1'h0; // R11
		end
		next_timer_zero_ext_clock = device_config[CFG_T0_SEL] &&
			pin_in[PIN_FOUR]; // R07
		next_master_clear_reset = device_config[CFG_MASTER_CLEAR_RESET_SEL] &&
			!pin_in[PIN_FIVE]; // R03 R04
	end

	// register pin side outputs
	always_ff @(posedge clock)
	begin
		if (sys_rst)
		begin
			pin_out <= 8'h00;
			pin_oe <= 8'h00;
			timer_zero_ext_clock <= 1'h0;
			master_clear_reset <= 1'h0;
		end
		else
		begin
			pin_out <= next_pin_out;
			pin_oe <= next_pin_oe;
			timer_zero_ext_clock <= next_timer_zero_ext_clock;
			master_clear_reset <= next_master_clear_reset;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	sequence s_port_read_setup;
		psel && !penable && !pwrite && paddr == ADDR_PORT_A_LATCH;
	endsequence

	sequence s_vref_read_setup;
		psel && !penable && !pwrite && paddr == ADDR_VOLTAGE_REF_CONTROL;
	endsequence

	property p_open_drain;
		@(posedge clock) disable iff (sys_rst) pin_oe[PIN_FOUR] |-> !pin_out[PIN_FOUR];
	endproperty
	a_open_drain: assert property (p_open_drain) // R01
		else $error("pin four driven high");

	property p_quarter_clock_output;
		@(posedge clock) disable iff (sys_rst)
			osc_mode == OSC_RC_QUARTER_CLOCK_OUTPUT |=> pin_oe[PIN_QUARTER_CLOCK_OUTPUT] &&
			pin_out[PIN_QUARTER_CLOCK_OUTPUT] == $past(quarter_clock_output);
	endproperty
	a_quarter_clock_output: assert property (p_quarter_clock_output) // R02
		else $error("clock out pin not carrying quarter clock");

	property p_master_clear_reset;
		@(posedge clock) disable iff (sys_rst)
			device_config[CFG_MASTER_CLEAR_RESET_SEL] && !pin_in[PIN_FIVE] |=>
			master_clear_reset ##1 port_a_latch[3:0] == 4'h0;
	endproperty
	a_master_clear_reset: assert property (p_master_clear_reset) // R03
		else $error("master clear did not reset the device");

	property p_pin_five;
		@(posedge clock) disable iff (sys_rst)
			!device_config[CFG_MASTER_CLEAR_RESET_SEL] |=> !master_clear_reset && !pin_oe[PIN_FIVE];
	endproperty
	a_pin_five: assert property (p_pin_five) // R04
		else $error("pin five acted as reset or output");

	property p_reset_values;
		@(posedge clock) $past(sys_rst) && !sys_rst |->
			port_a_latch[3:0] == 4'h0 && port_a_direction == RST_PORT_A_DIRECTION;
	endproperty
	a_reset_values: assert property (p_reset_values) // R05
		else $error("wrong register values after reset");

	property p_vref_bit4;
		@(posedge clock) disable iff (sys_rst) s_vref_read_setup |=> !prdata[4];
	endproperty
	a_vref_bit4: assert property (p_vref_bit4) // R06
		else $error("unimplemented bit read as one");

	property p_direction;
		@(posedge clock) disable iff (sys_rst)
			comparator_mode == CMP_MODE_OFF && !port_a_direction[0] |=>
			pin_oe[0] && pin_out[0] == $past(port_a_latch[0]);
	endproperty
	a_direction: assert property (p_direction) // R08
		else $error("cleared direction bit did not drive the pin");

	property p_rmw;
		@(posedge clock) disable iff (sys_rst)
			write_now && paddr == ADDR_PORT_A_LATCH && pstrb == 4'h0 &&
			!master_clear_reset |=> port_a_latch == $past(port_read);
	endproperty
	a_rmw: assert property (p_rmw) // R09
		else $error("latch not loaded from pins");

	property p_cmp_inputs;
		@(posedge clock) disable iff (sys_rst)
			s_port_read_setup and comparator_mode != CMP_MODE_OFF |=>
			prdata[2:0] == 3'h0;
	endproperty
	a_cmp_inputs: assert property (p_cmp_inputs) // R10
		else $error("comparator input read nonzero");

	property p_osc_pins;
		@(posedge clock) disable iff (sys_rst)
			osc_mode == OSC_CRYSTAL |=> !pin_oe[PIN_OSC_IN] && !pin_oe[PIN_QUARTER_CLOCK_OUTPUT];
	endproperty
	a_osc_pins: assert property (p_osc_pins) // R11
		else $error("oscillator pin driven as port");

	property p_cmp_out;
		@(posedge clock) disable iff (sys_rst)
			cmp_outputs_on |=> pin_oe[PIN_CMP1] && pin_out[PIN_CMP1] == $past(c1out);
	endproperty
	a_cmp_out: assert property (p_cmp_out) // R12
		else $error("comparator output lost the pin");

	property p_timer_clock;
		@(posedge clock) disable iff (sys_rst)
			device_config[CFG_T0_SEL] |=> timer_zero_ext_clock == $past(pin_in[PIN_FOUR]);
	endproperty
	a_timer_clock: assert property (p_timer_clock) // R07
		else $error("timer clock not following pin four");

endmodule

/* tb/pafn_pin_model.sv */
// Purpose: far side of the eight port pins
// Assumes: block drive wins over the external driver
// Notes: a pin released by the block and not driven by the bench floats up through a pull-up
`timescale 1ns/1ps
module pafn_pin_model
(
	// drive from the block
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe,
	// external driver set by the bench
	input wire logic [7:0] ext_en,
	input wire logic [7:0] ext_val,
	// resolved levels
	output logic [7:0] pin_in
);
	// block drive, else external driver, else pull-up
	always_comb
	begin
		for (int i = 0; i < 8; i++)
		begin
			if (pin_oe[i])
				pin_in[i] = pin_out[i];
			else if (ext_en[i])
				pin_in[i] = ext_val[i];
			else
				pin_in[i] = 1'b1;
		end
	end
endmodule

/* tb/tb_top.sv */
// Purpose: self-checking bench for the port pin function block
// Assumes: zero-wait apb slave, pull-ups on all pins
// Notes: pin outputs are judged two edges after their cause
`timescale 1ns/1ps
module tb_top
	import pafn_pkg::*;
;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [3:0] pstrb = 4'h0;
	logic internal_oscillator = 1'b0;
	logic cmp1_result = 1'b0;
	logic second_comparator_output_result = 1'b0;
	logic [7:0] ext_en = 8'h00;
	logic [7:0] ext_val = 8'h00;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [7:0] pin_in;
	logic [7:0] pin_out;
	logic [7:0] pin_oe;
	logic timer_zero_ext_clock;
	logic master_clear_reset;
	logic [2:0] comparator_mode;
	logic comparator_input_switch;
	logic vref_enable;
	logic vref_pin_enable;
	logic vref_range;
	logic [3:0] vref_level;
	logic [31:0] rdv;
	logic err;
	int mismatches = 0;
	int checked = 0;

	////////////////////////////////////////////////////////////////////////
	// design, far side and clock
	pafn_top pafn_top_inst (.clock(clock), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
		.internal_oscillator(internal_oscillator),
		.cmp1_result(cmp1_result), .second_comparator_output_result(second_comparator_output_result),
		.comparator_mode(comparator_mode),
		.comparator_input_switch(comparator_input_switch),
		.vref_enable(vref_enable), .vref_pin_enable(vref_pin_enable),
		.vref_range(vref_range), .vref_level(vref_level),
		.timer_zero_ext_clock(timer_zero_ext_clock),
		.master_clear_reset(master_clear_reset));
	pafn_pin_model pafn_pin_model_inst (.pin_out(pin_out), .pin_oe(pin_oe),
		.ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));
	always #4 clock = ~clock;

	////////////////////////////////////////////////////////////////////////
	// shared tasks
	task automatic chk(input string nm, input logic [31:0] seen, exp);
		checked++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [7:0] d, input logic s);
		int n;
		n = 0;
		@(posedge clock);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		pstrb <= {3'h0, s};
		@(posedge clock);
		penable <= 1'b1;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (n >= 50)
			chk("pready", 32'h0, 32'h1);
		rdv = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, a, d, 1'b1);
	endtask

	task automatic rd(input logic [11:0] a);
		apb(1'b0, a, 8'h00, 1'b1);
	endtask

	task automatic ws(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	task automatic pins(input logic [7:0] en, input logic [7:0] val);
		@(posedge clock);
		ext_en <= en;
		ext_val <= val;
	endtask

	////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_reset();
		rd(ADDR_PORT_A_LATCH);
		chk("port", rdv, 32'hF0);
		rd(ADDR_PORT_A_DIRECTION);
		chk("dir", rdv, 32'hFF);
		rd(ADDR_COMPARATOR_CONTROL);
		chk("cmp", rdv, 32'h00);
		rd(12'h3FC);
		chk("unmapped", {rdv[30:0], err}, 32'h1);
		wr(ADDR_VOLTAGE_REF_CONTROL, 8'hFF);
		rd(ADDR_VOLTAGE_REF_CONTROL);
		chk("vref", rdv, 32'hEF);
		chk("vref ctl", {vref_enable, vref_pin_enable, vref_range,
			vref_level}, 32'h7F);
		wr(ADDR_VOLTAGE_REF_CONTROL, 8'h00);
	endtask

	task automatic t_dir();
		wr(ADDR_COMPARATOR_CONTROL, 8'h07);
		wr(ADDR_DEVICE_CONFIG, 8'h00);
		wr(ADDR_PORT_A_LATCH, 8'h5A);
		wr(ADDR_PORT_A_DIRECTION, 8'h00);
		ws(2);
		chk("oe", pin_oe & 8'hEF, 8'hCF);
		chk("out", pin_out & 8'hCF, 8'h4A);
		chk("pin4 high", pin_oe[4] & pin_out[4], 1'b0);
		rd(ADDR_PORT_A_LATCH);
		chk("port", rdv, 32'h7A);
		wr(ADDR_PORT_A_LATCH, 8'h4A);
		ws(2);
		chk("pin4", {pin_oe[4], pin_out[4]}, 2'b10);
		wr(ADDR_PORT_A_DIRECTION, 8'hFF);
		ws(2);
		chk("oe off", pin_oe, 8'h00);
	endtask

	task automatic t_rmw();
		pins(8'hFF, 8'h96);
		ws(2);
		rd(ADDR_PORT_A_LATCH);
		chk("port", rdv, 32'h96);
		chk("no master_clear_reset", master_clear_reset, 1'b0);
		apb(1'b1, ADDR_PORT_A_LATCH, 8'h00, 1'b0);
		pins(8'h00, 8'h00);
		wr(ADDR_PORT_A_DIRECTION, 8'h00);
		ws(2);
		chk("rmw", pin_out & 8'hCF, 8'h86);
		chk("pin5", pin_oe[5], 1'b0);
		wr(ADDR_PORT_A_DIRECTION, 8'hFF);
	endtask

	task automatic t_cmp();
		@(posedge clock);
		cmp1_result <= 1'b1;
		wr(ADDR_COMPARATOR_CONTROL, 8'h06);
		pins(8'h07, 8'h07);
		ws(2);
		chk("cmp oe", pin_oe[4:3], 2'b11);
		chk("cmp out", pin_out[4:3], 2'b01);
		rd(ADDR_PORT_A_LATCH);
		chk("port", rdv, 32'hE8);
		rd(ADDR_COMPARATOR_CONTROL);
		chk("cmp", rdv, 32'h46);
		chk("cmp ctl", {comparator_input_switch, comparator_mode},
			32'h6);
		@(posedge clock);
		second_comparator_output_result <= 1'b1;
		ws(3);
		chk("second_comparator_output od", pin_oe[4], 1'b0);
		wr(ADDR_COMPARATOR_CONTROL, 8'h07);
		wr(ADDR_DEVICE_CONFIG, 8'h08);
		pins(8'h10, 8'h00);
		ws(2);
		chk("t0 low", timer_zero_ext_clock, 1'b0);
		pins(8'h10, 8'h10);
		ws(2);
		chk("t0 high", timer_zero_ext_clock, 1'b1);
		wr(ADDR_DEVICE_CONFIG, 8'h00);
		ws(2);
		chk("t0 off", timer_zero_ext_clock, 1'b0);
		pins(8'h00, 8'h00);
	endtask

	task automatic t_osc();
		int tg;
		logic prev;
		tg = 0;
		wr(ADDR_DEVICE_CONFIG, 8'h02);
		ws(2);
		prev = pin_out[6];
		for (int i = 0; i < 72; i++)
		begin
			@(posedge clock);
			if (i % 2 == 0 && i < 64)
				internal_oscillator <= ~internal_oscillator;
			#1;
			if (pin_out[6] !== prev)
				tg++;
			prev = pin_out[6];
		end
		chk("quarter", tg, 8);
		chk("clk oe", pin_oe[6], 1'b1);
		wr(ADDR_DEVICE_CONFIG, 8'h04);
		pins(8'h80, 8'h00);
		ws(2);
		chk("rc oe", pin_oe[7:6], 2'b01);
		wr(ADDR_DEVICE_CONFIG, 8'h06);
		pins(8'hC0, 8'hC0);
		wr(ADDR_PORT_A_DIRECTION, 8'h00);
		ws(2);
		chk("osc oe", pin_oe[7:6], 2'b00);
		rd(ADDR_PORT_A_LATCH);
		chk("osc read", rdv & 32'hC0, 32'h0);
		wr(ADDR_PORT_A_DIRECTION, 8'hFF);
		pins(8'h00, 8'h00);
	endtask

	task automatic t_master_clear_reset();
		wr(ADDR_DEVICE_CONFIG, 8'h00);
		wr(ADDR_PORT_A_LATCH, 8'hC3);
		wr(ADDR_DEVICE_CONFIG, 8'h01);
		pins(8'h20, 8'h00);
		ws(2);
		chk("master_clear_reset", master_clear_reset, 1'b1);
		wr(ADDR_PORT_A_DIRECTION, 8'h00);
		pins(8'h00, 8'h00);
		ws(3);
		rd(ADDR_PORT_A_DIRECTION);
		chk("dir", rdv, 32'hFF);
		wr(ADDR_PORT_A_DIRECTION, 8'h00);
		ws(2);
		chk("kept", pin_out & 8'hCF, 8'hC0);
		wr(ADDR_PORT_A_DIRECTION, 8'hFF);
	endtask

	////////////////////////////////////////////////////////////////////////
	// verdict, main sequence and watchdog
	task automatic summarize();
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial
	begin
		repeat (2) @(posedge clock);
		sys_rst <= 1'b0;
		t_reset();
		t_dir();
		t_rmw();
		t_cmp();
		t_osc();
		t_master_clear_reset();
		summarize();
	end

	initial
	begin
		repeat (5000) @(posedge clock);
		mismatches++;
		summarize();
	end
endmodule
